// ==== logic/pms_power_mode_sequencer.sv ====
// Power mode sequencer: disable pin, power-on reset, System ON sub-modes, System OFF
//
// Overview of operation
// - Enable pin low keeps regulator off
// - Enable pin high turns regulator on
// - Disabled to enabled performs power-on reset
// - System OFF entered only by software request
// - System OFF powers core down, stops tasks
// - Wake on detect, reset or debug start
// - Every wake from OFF is a system reset
// - Retained RAM blocks keep contents in OFF
// - RAM settings survive a system reset
// - Debug session emulates OFF, all stays powered
// - After power-on reset: ON, low power
// - No activity in low power gives idle
// - Activity leaves idle, completion returns
// - Regulator and clock demand follow activity in low power
// - Constant latency task selects constant latency
// - Constant latency keeps base resources enabled
// - Low power task returns to low power
// - Unused RAM blocks powered off during idle
`timescale 1ns/1ns
`default_nettype none

module pms_power_mode_sequencer
  import pms_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Pins and debug port, asynchronous
  input  wire logic        enable_pin_i,
  input  wire logic        ext_reset_n_i,
  input  wire logic        debug_session_i,
  // Same-clock inputs from the system
  input  wire logic        gpio_detect_i,
  input  wire logic        app_busy_i,
  input  wire logic        modem_busy_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Power and reset controls
  output logic             regulator_en_o,
  output logic             por_o,
  output logic             sys_reset_o,
  output logic             core_power_o,
  output logic             clocks_on_o,
  output logic             task_stop_o,
  output logic             idle_o,
  output logic             base_res_on_o,
  output logic             res_demand_o,
  output logic      [7:0]  ram_power_o,
  output logic      [7:0]  ram_retain_o
);

  // ********************************************************************
  // Helper functions
  // ********************************************************************

  // Word decode, low two address bits ignored
  function automatic logic word_hit(input logic [7:0] adr, input logic [7:0] ofs);
    word_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Byte-lane merge for a 16-bit field
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] dat,
                                             input logic [3:0]  sel);
    lane_merge = old_v;
    if (sel[0])
    begin
      lane_merge[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      lane_merge[15:8] = dat[15:8];
    end
  endfunction

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic       dbg_d_ff;
  logic [2:0] nxt_sync1;
  logic [2:0] nxt_sync2;
  logic       nxt_dbg_d;
  logic       en_s;
  logic       rst_pin_s;
  logic       dbg_s;
  logic       dbg_start;

  // Stage one is read only by stage two
  always_comb
  begin
    nxt_sync1 = {debug_session_i, ~ext_reset_n_i, enable_pin_i};
    nxt_sync2 = sync1_ff;
    nxt_dbg_d = sync2_ff[2];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      dbg_d_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      dbg_d_ff <= nxt_dbg_d;
    end
  end

  assign en_s      = sync2_ff[0];
  assign rst_pin_s = sync2_ff[1];
  assign dbg_s     = sync2_ff[2];
  assign dbg_start = dbg_s & ~dbg_d_ff;   // Rising edge of a debug session

  // ********************************************************************
  // Wishbone slave
  // ********************************************************************
  logic         ack_ff;
  logic [31:0]  rdat_ff;
  logic         nxt_ack;
  logic [31:0]  nxt_rdat;
  logic         bus_wr;
  logic         cl_task;
  logic         lp_task;
  logic         sysoff_req;
  logic         ram_wr;
  logic         cause_wr;
  pms_state_t   st_ff;
  logic         cl_ff;
  pms_ram_cfg_t ram_ff;
  pms_cause_t   cause_ff;

  // Write acts on the edge where the master samples ack
  assign bus_wr     = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign cl_task    = bus_wr & word_hit(wb_adr_i, OFS_TASK_CL) & wb_sel_i[0] & wb_dat_i[0];
  assign lp_task    = bus_wr & word_hit(wb_adr_i, OFS_TASK_LP) & wb_sel_i[0] & wb_dat_i[0];
  assign sysoff_req = bus_wr & word_hit(wb_adr_i, OFS_SYSOFF) & wb_sel_i[0] & wb_dat_i[0];
  assign ram_wr     = bus_wr & word_hit(wb_adr_i, OFS_RAM_CFG);
  assign cause_wr   = bus_wr & word_hit(wb_adr_i, OFS_WAKE_CAUSE) & wb_sel_i[0];

  // One wait state; unmapped reads return zero, unmapped writes are dropped
  always_comb
  begin
    nxt_ack  = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_rdat = 32'h0000_0000;
    if (word_hit(wb_adr_i, OFS_STATUS))
    begin
      nxt_rdat[5:0]           = st_ff;
      nxt_rdat[STAT_CL_BIT]   = cl_ff;
      nxt_rdat[STAT_IDLE_BIT] = idle_o;
      nxt_rdat[STAT_EMU_BIT]  = (st_ff == ST_EMUOFF);
    end
    else if (word_hit(wb_adr_i, OFS_RAM_CFG))
    begin
      nxt_rdat[15:0] = ram_ff;
    end
    else if (word_hit(wb_adr_i, OFS_WAKE_CAUSE))
    begin
      nxt_rdat[3:0] = cause_ff;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ********************************************************************
  // Power mode state machine
  // ********************************************************************
  logic [4:0]   cnt_ff;
  pms_state_t   nxt_st;
  logic [4:0]   nxt_cnt;
  logic         nxt_cl;
  pms_ram_cfg_t nxt_ram;
  pms_cause_t   nxt_cause;
  logic         wake_any;
  logic         busy;

  assign wake_any = gpio_detect_i | rst_pin_s | dbg_start;
  assign busy     = app_busy_i | modem_busy_i;

  // Clear comes first so a wake in the same cycle keeps its flag
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_cl    = cl_ff;
    nxt_ram   = ram_ff;
    nxt_cause = cause_ff;
    if (cause_wr)
    begin
      nxt_cause = cause_ff & ~pms_cause_t'(wb_dat_i[3:0]);
    end
    if (ram_wr)
    begin
      nxt_ram = lane_merge(ram_ff, wb_dat_i, wb_sel_i);
    end
    case (st_ff)
      ST_DISABLED:
      begin
        if (en_s)
        begin
          nxt_st  = ST_POR;
          nxt_cnt = POR_LAST;
        end
      end
      ST_POR:
      begin
        // Full reset clears even the retained settings
        nxt_ram   = RAM_CFG_RST;
        nxt_cl    = 1'b0;
        nxt_cause = CAUSE_RST;
        if (cnt_ff == 5'h00)
        begin
          nxt_st = ST_ON;
        end
        else
        begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
      ST_ON:
      begin
        if (rst_pin_s)
        begin
          nxt_st          = ST_WAKERST;
          nxt_cnt         = RST_LAST;
          nxt_cause.reset = 1'b1;
        end
        else if (sysoff_req)
        begin
          // Debug keeps everything alive; software must spin after the request
          nxt_st = dbg_s ? ST_EMUOFF : ST_OFF;
        end
        else if (cl_task && !lp_task)
        begin
          nxt_cl = 1'b1;
        end
        else if (lp_task && !cl_task)
        begin
          nxt_cl = 1'b0;
        end
      end
      ST_OFF, ST_EMUOFF:
      begin
        if (wake_any)
        begin
          nxt_st           = ST_WAKERST;
          nxt_cnt          = RST_LAST;
          // Built on the cleared value so a clear of other causes still lands
          nxt_cause.detect = nxt_cause.detect | gpio_detect_i;
          nxt_cause.reset  = nxt_cause.reset | rst_pin_s;
          nxt_cause.debug  = nxt_cause.debug | dbg_start;
        end
      end
      ST_WAKERST:
      begin
        // System reset: sub-mode back to default, RAM settings kept
        nxt_cl = 1'b0;
        if (cnt_ff == 5'h00)
        begin
          nxt_st = ST_ON;
        end
        else
        begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
      default:
      begin
        nxt_st = ST_DISABLED;
      end
    endcase
    // Pin override beats every internal mode
    if (!en_s)
    begin
      nxt_st = ST_DISABLED;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff    <= ST_DISABLED;
      cnt_ff   <= 5'h00;
      cl_ff    <= 1'b0;
      ram_ff   <= RAM_CFG_RST;
      cause_ff <= CAUSE_RST;
    end
    else if (ce_i)
    begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      cl_ff    <= nxt_cl;
      ram_ff   <= nxt_ram;
      cause_ff <= nxt_cause;
    end
  end

  // ********************************************************************
  // Power and clock controls
  // ********************************************************************

  // Decoded from state flops; idle_o, res_demand_o and ram_power_o also follow the busy inputs combinationally
  always_comb
  begin
    regulator_en_o = (st_ff != ST_DISABLED);
    por_o          = (st_ff == ST_POR);
    sys_reset_o    = (st_ff == ST_WAKERST);
    core_power_o   = (st_ff == ST_ON) || (st_ff == ST_POR) ||
                     (st_ff == ST_WAKERST) || (st_ff == ST_EMUOFF);
    clocks_on_o    = core_power_o;
    task_stop_o    = (st_ff == ST_OFF);
    idle_o         = (st_ff == ST_ON) && !cl_ff && !busy;
    base_res_on_o  = (st_ff == ST_ON) && cl_ff;
    res_demand_o   = ((st_ff == ST_ON) && (cl_ff || busy)) ||
                     (st_ff == ST_EMUOFF);
    ram_retain_o   = 8'h00;
    ram_power_o    = 8'h00;
    case (st_ff)
      ST_OFF:
      begin
        ram_retain_o = ram_ff.retain;
      end
      ST_ON:
      begin
        ram_retain_o = ram_ff.retain;
        ram_power_o  = idle_o ? ram_ff.power : 8'hFF;
      end
      ST_POR, ST_WAKERST, ST_EMUOFF:
      begin
        ram_power_o = 8'hFF;
      end
      default:
      begin
        ram_power_o = 8'h00;
      end
    endcase
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  sequence s_pin_low;
    !en_s && ce_i;
  endsequence

  sequence s_power_up;
    (st_ff == ST_DISABLED) && en_s && ce_i;
  endsequence

  sequence s_off_wake;
    ((st_ff == ST_OFF) || (st_ff == ST_EMUOFF)) && en_s && ce_i && wake_any;
  endsequence

  chk_pin_low_off: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pin_low |=> !regulator_en_o)
    else $error("regulator on while enable pin low");

  chk_power_up_por: assert property (@(posedge clk_i) disable iff (rst_i)
    s_power_up |=> regulator_en_o && por_o && (cnt_ff == POR_LAST))
    else $error("no power-on reset after enable");

  chk_por_to_lp: assert property (@(posedge clk_i) disable iff (rst_i)
    (por_o && ce_i && en_s && (cnt_ff == 5'h00)) |=> (st_ff == ST_ON) && !cl_ff)
    else $error("power-on reset did not end in low power");

  chk_off_by_sw: assert property (@(posedge clk_i) disable iff (rst_i)
    ((st_ff == ST_ON) ##1 (st_ff == ST_OFF)) |-> $past(sysoff_req) && !$past(dbg_s))
    else $error("System OFF without software request");

  chk_off_core_down: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == ST_OFF) |-> !core_power_o && task_stop_o && (ram_power_o == 8'h00)
                          && (ram_retain_o == ram_ff.retain))
    else $error("core or RAM powered in System OFF");

  chk_wake_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    s_off_wake |=> sys_reset_o && (cnt_ff == RST_LAST))
    else $error("wake did not give a system reset");

  chk_ram_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (sys_reset_o && ce_i && !ram_wr) |=> (ram_ff == $past(ram_ff)))
    else $error("RAM settings lost across system reset");

  chk_emu_powered: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == ST_EMUOFF) |-> core_power_o && clocks_on_o && (ram_power_o == 8'hFF))
    else $error("emulated OFF dropped a resource");

  chk_idle_cond: assert property (@(posedge clk_i) disable iff (rst_i)
    ((st_ff == ST_ON) && !cl_ff) |-> (idle_o == !(app_busy_i || modem_busy_i)))
    else $error("idle does not follow activity");

  chk_cl_select: assert property (@(posedge clk_i) disable iff (rst_i)
    ((st_ff == ST_ON) && en_s && ce_i && !rst_pin_s && !sysoff_req && cl_task && !lp_task)
      |=> cl_ff && base_res_on_o && !idle_o)
    else $error("constant latency not selected");

  chk_lp_select: assert property (@(posedge clk_i) disable iff (rst_i)
    ((st_ff == ST_ON) && en_s && ce_i && !rst_pin_s && !sysoff_req && lp_task && !cl_task)
      |=> !cl_ff && !base_res_on_o)
    else $error("low power not selected");

endmodule

`default_nettype wire

// ==== include/pms_pkg.sv ====
// Package with constants, types and register map of the power mode sequencer
package pms_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_TIME_NS   = 160;   // Internal power-on reset hold time
  localparam int RST_TIME_NS   = 80;    // Internal system reset hold time
  localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYCLES    = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] POR_LAST = 5'(POR_CYCLES - 1);
  localparam logic [4:0] RST_LAST = 5'(RST_CYCLES - 1);

  // ********************************************************************
  // Register map (byte addresses, one word each)
  // ********************************************************************
  localparam logic [7:0] OFS_TASK_CL    = 8'h00;  // constant_latency_task
  localparam logic [7:0] OFS_TASK_LP    = 8'h04;  // low_power_select_task
  localparam logic [7:0] OFS_SYSOFF     = 8'h08;  // System OFF request
  localparam logic [7:0] OFS_STATUS     = 8'h0C;  // Mode and idle status
  localparam logic [7:0] OFS_RAM_CFG    = 8'h10;  // RAM power and retention
  localparam logic [7:0] OFS_WAKE_CAUSE = 8'h14;  // Sticky wake causes, write 1 clears

  // Field positions
  localparam int STAT_CL_BIT   = 8;
  localparam int STAT_IDLE_BIT = 9;
  localparam int STAT_EMU_BIT  = 10;
  localparam int RAM_BLOCKS    = 8;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [5:0] {
    ST_DISABLED = 6'h01,
    ST_POR      = 6'h02,
    ST_ON       = 6'h04,
    ST_OFF      = 6'h08,
    ST_EMUOFF   = 6'h10,
    ST_WAKERST  = 6'h20
  } pms_state_t;

  typedef struct packed {
    logic [7:0] retain;   // Bits [15:8]
    logic [7:0] power;    // Bits [7:0], on while idle when set
  } pms_ram_cfg_t;

  typedef struct packed {
    logic por;            // Bit 3
    logic debug;          // Bit 2
    logic reset;          // Bit 1
    logic detect;         // Bit 0
  } pms_cause_t;

  localparam pms_ram_cfg_t RAM_CFG_RST = '{retain: 8'h00, power: 8'hFF};
  localparam pms_cause_t   CAUSE_RST   = '{por: 1'b1, debug: 1'b0, reset: 1'b0, detect: 1'b0};

endpackage

// ==== test/pms_host_model.sv ====
// Host board logic that drives the enable, reset and debug pins
`timescale 1ns/1ns
`default_nettype none

module pms_host_model
(
  // Clock and host commands
  input  wire logic clk_i,
  input  wire logic pwr_req_i,
  input  wire logic rst_req_i,
  input  wire logic dbg_req_i,
  // Pins seen by the device
  output var  logic enable_pin_o = 1'b0,
  output var  logic reset_n_o    = 1'b1,
  output var  logic debug_o      = 1'b0
);

  // Pins move one edge after a command, like a clocked board controller
  always @(posedge clk_i)
  begin
    enable_pin_o <= pwr_req_i;
    reset_n_o    <= ~rst_req_i;
    debug_o      <= dbg_req_i;
  end

endmodule

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking testbench of the power mode sequencer
`timescale 1ns/1ns
`default_nettype none

module tb import pms_pkg::*;;

  // ******************************
  // Signals
  // ******************************
  logic        clk_i, rst_i, pwr, rreq, dbg, det, busy_a, busy_m;
  logic        en_pin, rst_n_pin, dbg_pin, wb_cyc, wb_stb, wb_we, wb_ack_o;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_dat_o;
  logic        regulator_en_o, por_o, sys_reset_o, core_power_o, clocks_on_o;
  logic        task_stop_o, idle_o, base_res_on_o, res_demand_o;
  logic [7:0]  ram_power_o, ram_retain_o;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  // Pin driver on the far side
  pms_host_model host_u (.clk_i(clk_i), .pwr_req_i(pwr), .rst_req_i(rreq),
    .dbg_req_i(dbg), .enable_pin_o(en_pin), .reset_n_o(rst_n_pin), .debug_o(dbg_pin));

  // Device under test; clock enable stays high throughout
  pms_power_mode_sequencer dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .enable_pin_i(en_pin), .ext_reset_n_i(rst_n_pin), .debug_session_i(dbg_pin),
    .gpio_detect_i(det), .app_busy_i(busy_a), .modem_busy_i(busy_m),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .regulator_en_o(regulator_en_o), .por_o(por_o), .sys_reset_o(sys_reset_o),
    .core_power_o(core_power_o), .clocks_on_o(clocks_on_o), .task_stop_o(task_stop_o),
    .idle_o(idle_o), .base_res_on_o(base_res_on_o), .res_demand_o(res_demand_o),
    .ram_power_o(ram_power_o), .ram_retain_o(ram_retain_o));

  // ******************************
  // Clock, timeout and helpers
  // ******************************
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // The whole run needs well under two thousand cycles
  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One classic cycle; request held until ack is sampled, then one idle cycle
  // No local limit: a slave that never answers is caught by the run timeout
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] rd);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do
    begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb_xfer(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    wb_xfer(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask

  // Poll the state field with a bounded number of reads
  task automatic wait_state(input logic [5:0] st);
    logic [31:0] x;
    int n;
    n = 0;
    x = '0;
    while (x[5:0] !== st && n < 40)
    begin
      wb_xfer(1'b0, OFS_STATUS, 32'h0, x);
      n++;
    end
    check(32'(x[5:0]), 32'(st));
  endtask

  // ******************************
  // Scenarios
  // ******************************
  task automatic t_power_up();
    check(32'(regulator_en_o), 32'h0);
    pwr <= 1'b1;
    cyc(5);
    check(32'(por_o), 32'h1);
    check(32'(regulator_en_o), 32'h1);
    wait_state(ST_ON);
    rdchk(OFS_STATUS, 32'h204);
    rdchk(OFS_RAM_CFG, 32'h00FF);
    rdchk(OFS_WAKE_CAUSE, 32'h8);
  endtask

  task automatic t_idle();
    wr(OFS_RAM_CFG, 32'h300F);
    busy_a <= 1'b1;
    cyc(2);
    check(32'(idle_o), 32'h0);
    check(32'(res_demand_o), 32'h1);
    check(32'(ram_power_o), 32'hFF);
    busy_a <= 1'b0;
    busy_m <= 1'b1;
    cyc(2);
    check(32'(idle_o), 32'h0);
    busy_m <= 1'b0;
    cyc(2);
    check(32'(idle_o), 32'h1);
    check(32'(res_demand_o), 32'h0);
    check(32'(ram_power_o), 32'h0F);
  endtask

  // Each task written twice; the second write must change nothing
  task automatic t_sub_modes();
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_TASK_CL, 32'h1);
      check(32'(base_res_on_o), 32'h1);
      check(32'(idle_o), 32'h0);
      rdchk(OFS_STATUS, 32'h104);
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_TASK_LP, 32'h1);
      check(32'(base_res_on_o), 32'h0);
      rdchk(OFS_STATUS, 32'h204);
    end
  endtask

  // Real System OFF, woken by detect, reset pin and debug start in turn
  task automatic t_off_wake();
    for (int c = 0; c < 3; c++)
    begin
      wr(OFS_WAKE_CAUSE, 32'hF);
      rdchk(OFS_STATUS, 32'h204);
      wr(OFS_SYSOFF, 32'h1);
      cyc(4);
      check(32'(task_stop_o), 32'h1);
      check(32'(core_power_o), 32'h0);
      check(32'(ram_power_o), 32'h00);
      check(32'(ram_retain_o), 32'h30);
      if (c == 0)
        det <= 1'b1;
      else if (c == 1)
        rreq <= 1'b1;
      else
        dbg <= 1'b1;
      cyc(1);
      det  <= 1'b0;
      rreq <= 1'b0;
      cyc(5);
      check(32'(sys_reset_o), 32'h1);
      wait_state(ST_ON);
      rdchk(OFS_RAM_CFG, 32'h300F);
      rdchk(OFS_WAKE_CAUSE, 32'h1 << c);
      dbg <= 1'b0;
      cyc(4);
    end
  endtask

  task automatic t_emulated();
    dbg <= 1'b1;
    cyc(5);
    wr(OFS_SYSOFF, 32'h1);
    cyc(2);
    rdchk(OFS_STATUS, 32'h410);
    check(32'(core_power_o), 32'h1);
    check(32'(clocks_on_o), 32'h1);
    check(32'(task_stop_o), 32'h0);
    check(32'(ram_power_o), 32'hFF);
    det <= 1'b1;
    cyc(1);
    det <= 1'b0;
    wait_state(ST_ON);
    dbg <= 1'b0;
    rdchk(8'h18, 32'h0);
    wr(OFS_STATUS, 32'hFFFF);
    rdchk(OFS_STATUS, 32'h204);
  endtask

  task automatic t_disable();
    pwr <= 1'b0;
    cyc(6);
    check(32'(regulator_en_o), 32'h0);
    check(32'(ram_power_o), 32'h00);
    pwr <= 1'b1;
    cyc(5);
    check(32'(por_o), 32'h1);
    wait_state(ST_ON);
    rdchk(OFS_RAM_CFG, 32'h00FF);
  endtask

  // Main sequence: two reset cycles, then the scenarios
  initial
  begin
    rst_i  = 1'b1;
    pwr    = 1'b0;
    rreq   = 1'b0;
    dbg    = 1'b0;
    det    = 1'b0;
    busy_a = 1'b0;
    busy_m = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we  = 1'b0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    cyc(2);
    rst_i <= 1'b0;
    cyc(1);
    t_power_up();
    t_idle();
    t_sub_modes();
    t_off_wake();
    t_emulated();
    t_disable();
    close_out();
  end

endmodule

`default_nettype wire
